/* File: bench/host_model.sv */
// Purpose: Behavioural host motion controller facing the limiter.
// Assumes: One clock; commands change just after a rising edge.
// Notes: The host limit flag mirrors what a real host would apply in host-limited mode.
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic clk_sys,           // System clock.
	input  wire logic srst,              // Synchronous reset.
	input  wire logic uv_warning,        // Warning seen from the drive.
	input  wire logic off_req,           // Bench asks for immediate de-energize.
	output logic      servo_on_request,  // Servo on command level.
	output logic      servo_off_command, // Servo off command level.
	output logic      host_limit         // Host applies its own torque limit.
);
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			servo_on_request  <= 1'b0;
			servo_off_command <= 1'b0;
			host_limit        <= 1'b0;
		end
		else
		begin
			servo_on_request  <= ~off_req;
			servo_off_command <= off_req;
			host_limit        <= uv_warning;
		end
	end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: Self-checking bench for the undervoltage torque limiter.
// Assumes: Tick shortened to 10 cycles, so one millisecond is 10 clocks.
// Notes: Host config includes out-of-range writes to check clamping, and stays above any holding torque.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import uv_limit_pkg::*;
	logic clk_sys = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic bus_low = 1'b0, supply_lost = 1'b0, off_req = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        avs_waitrequest, uv_warning, torque_limit_en, servo_ready;
	logic        servo_energized, irq, servo_on_request, servo_off_command, host_limit;
	logic [15:0] torque_limit;
	int          failures = 0, n_compared = 0, n;
	always #5 clk_sys = ~clk_sys;
	uv_torque_limiter #(.TICK_COUNT(10)) dut_u (.clk_sys(clk_sys), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_low(bus_low),
		.supply_lost(supply_lost), .servo_on_request(servo_on_request),
		.servo_off_command(servo_off_command), .uv_warning(uv_warning),
		.torque_limit_en(torque_limit_en), .torque_limit(torque_limit),
		.servo_ready(servo_ready), .servo_energized(servo_energized), .irq(irq));
	host_model host_u (.clk_sys(clk_sys), .srst(srst), .uv_warning(uv_warning),
		.off_req(off_req), .servo_on_request(servo_on_request),
		.servo_off_command(servo_off_command), .host_limit(host_limit));
	task automatic finish_test();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t %s: got %0h expected %0h", $time, msg, got, exp);
		end
	endtask
	// The request stays up until waitrequest is sampled low, then drops on that edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (i == 20)
		begin
			chk(1'b1, 1'b0, "bus timeout");
			finish_test();
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		bus(1'b0, a, 32'h0);
		chk(rd, exp, msg);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	initial
	begin
		#200_000;
		chk(1'b1, 1'b0, "watchdog");
		finish_test();
	end
	initial
	begin
		cyc(6);
		srst <= 1'b0;
		cyc(2);
		rchk(ADDR_SELECT, 32'h0, "select reset");
		rchk(ADDR_LEVEL, 32'h32, "level reset");
		rchk(ADDR_RELEASE, 32'h64, "release reset");
		rchk(ADDR_HOLD, 32'h14, "hold reset");
		rchk(8'h20, 32'h0, "unmapped");
		chk(torque_limit, 16'h0064, "limit idle");
		bus_low <= 1'b1;
		cyc(4);
		chk(uv_warning, 1'b0, "off mode warning");
		bus(1'b1, ADDR_SELECT, 32'h1);
		cyc(3);
		chk(uv_warning, 1'b1, "host mode warning");
		chk(torque_limit_en, 1'b0, "host mode no clamp");
		chk(host_limit, 1'b1, "host applies limit");
		chk(irq, 1'b0, "masked irq");
		bus(1'b1, ADDR_IRQ_MASK, 32'h1);
		cyc(1);
		chk(irq, 1'b1, "unmasked irq");
		bus_low <= 1'b0;
		cyc(3);
		chk(uv_warning, 1'b0, "warning release");
		chk(host_limit, 1'b0, "host removes limit");
		rchk(ADDR_IRQ_STAT, 32'h3, "irq status");
		bus(1'b1, ADDR_IRQ_STAT, 32'h7);
		cyc(1);
		chk(irq, 1'b0, "irq cleared");
		bus(1'b1, ADDR_LEVEL, 32'h5);
		rchk(ADDR_LEVEL, 32'hA, "level clamp low");
		bus(1'b1, ADDR_RELEASE, 32'h7D0);
		rchk(ADDR_RELEASE, 32'h3E8, "release clamp high");
		bus(1'b1, ADDR_LEVEL, 32'h1E);
		bus(1'b1, ADDR_RELEASE, 32'hA);
		bus(1'b1, ADDR_SELECT, 32'h2);
		bus_low <= 1'b1;
		cyc(5);
		chk(torque_limit_en, 1'b1, "drive clamp");
		chk(torque_limit, 16'h001E, "drive level");
		rchk(ADDR_LIMIT, 32'h1E, "limit readback");
		bus_low <= 1'b0;
		cyc(4);
		chk(uv_warning, 1'b0, "drive release");
		chk(torque_limit_en, 1'b1, "no instant removal");
		cyc(50);
		chk(torque_limit > 16'h001E && torque_limit < 16'h0064, 1'b1, "mid ramp");
		for (n = 0; n < 200 && torque_limit_en !== 1'b0; n++)
			cyc(1);
		chk(n > 20 && n < 100, 1'b1, "ramp length");
		chk(torque_limit, 16'h0064, "ramp end");
		chk(servo_energized, 1'b1, "energized");
		supply_lost <= 1'b1;
		cyc(100);
		chk(servo_ready, 1'b1, "short loss rides");
		supply_lost <= 1'b0;
		cyc(3);
		supply_lost <= 1'b1;
		for (n = 0; n < 400 && servo_ready !== 1'b0; n++)
			cyc(1);
		chk(n >= 200 && n <= 215, 1'b1, "trip time");
		chk(servo_energized, 1'b0, "trip de-energizes");
		rchk(ADDR_IRQ_STAT, 32'h7, "trip status");
		supply_lost <= 1'b0;
		cyc(4);
		chk(servo_ready, 1'b1, "ready returns");
		bus(1'b1, ADDR_HOLD, 32'h3E8);
		rchk(ADDR_HOLD, 32'h3E8, "hold write");
		off_req <= 1'b1;
		cyc(4);
		chk(servo_energized, 1'b0, "servo off");
		rchk(ADDR_STATUS, 32'h8, "status ready only");
		bus(1'b1, ADDR_SELECT, 32'h3);
		rchk(ADDR_SELECT, 32'h0, "select 3 is off");
		finish_test();
	end
endmodule
`default_nettype wire

/* File: hdl/ms_tick.sv */
// Purpose: Millisecond tick generator for the limiter timers.
// Assumes: Synchronous active-high reset.
// Notes: Count is a parameter so simulation can shorten it.
`timescale 1ns/10ps
`default_nettype none
module ms_tick #(
	parameter int CYCLES = 100000
) (
	input  wire logic clk_sys, // System clock.
	input  wire logic srst,    // Synchronous reset.
	output logic      tick     // One-cycle pulse each millisecond.
);
	logic [31:0] count;
	wire         wrap = (count == 32'(CYCLES - 1));

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			count <= 32'h0;
		else
			count <= wrap ? 32'h0 : count + 32'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			tick <= 1'b0;
		else
			tick <= wrap;
	end
endmodule
`default_nettype wire

/* File: hdl/uv_torque_limiter.sv */
// Purpose: Undervoltage detection with host or drive torque limiting and power-loss hold.
// Assumes: Bus voltage comparator and supply-loss detect arrive as synchronous levels.
// Notes: Registers are reached over Avalon-MM; every access answers one cycle late.
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module uv_torque_limiter
#(
	parameter int TICK_COUNT = uv_limit_pkg::TICK_CYCLES
) (
	input  wire logic        clk_sys,           // System clock, 100 MHz.
	input  wire logic        srst,              // Synchronous reset, active high.
	input  wire logic [7:0]  avs_address,       // Byte address.
	input  wire logic        avs_read,          // Read request.
	input  wire logic        avs_write,         // Write request.
	input  wire logic [31:0] avs_writedata,     // Write data.
	input  wire logic [3:0]  avs_byteenable,    // Byte enables.
	output logic [31:0]      avs_readdata,      // Read data.
	output logic             avs_waitrequest,   // Stall until answer.
	input  wire logic        bus_low,           // DC bus below threshold.
	input  wire logic        supply_lost,       // Main supply interrupted.
	input  wire logic        servo_on_request,  // Host servo on command.
	input  wire logic        servo_off_command, // Host servo off command.
	output logic             uv_warning,        // Undervoltage warning.
	output logic             torque_limit_en,   // Internal torque clamp active.
	output logic [15:0]      torque_limit,      // Torque limit, percent of rated.
	output logic             servo_ready,       // Servo ready.
	output logic             servo_energized,   // Motor energized.
	output logic             irq                // Level interrupt.
);
	import uv_limit_pkg::*;

	logic [1:0]          undervoltage_handling_select;
	logic [15:0]         undervoltage_torque_limit_level;
	logic [15:0]         torque_limit_release_time;
	logic [15:0]         power_loss_hold_time;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;
	logic                answered;
	lim_state_t          state;
	logic [15:0]         ramp_ms;
	logic [15:0]         loss_ms;
	logic                tripped;
	logic                warn_d;
	logic                tick;

	ms_tick #(.CYCLES(TICK_COUNT)) u_tick (
		.clk_sys (clk_sys),
		.srst    (srst),
		.tick    (tick)
	);

	// A request is answered in the cycle after it appears.
	wire access   = (avs_read || avs_write) && !answered;
	wire wr       = avs_write && answered;
	wire wr_sel   = wr && (avs_address == ADDR_SELECT) && avs_byteenable[0];
	wire wr_level = wr && (avs_address == ADDR_LEVEL) && (&avs_byteenable[1:0]);
	wire wr_rel   = wr && (avs_address == ADDR_RELEASE) && (&avs_byteenable[1:0]);
	wire wr_hold  = wr && (avs_address == ADDR_HOLD) && (&avs_byteenable[1:0]);
	wire wr_istat = wr && (avs_address == ADDR_IRQ_STAT) && avs_byteenable[0];
	wire wr_imask = wr && (avs_address == ADDR_IRQ_MASK) && avs_byteenable[0];
	wire [15:0] wdata16 = avs_writedata[15:0];

	assign avs_waitrequest = (avs_read || avs_write) && !answered;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			answered <= 1'b0;
		else
			answered <= access;
	end

	// Out-of-range select values fall back to off.
	wire [1:0] sel_new = (wdata16[1:0] == 2'h3) ? SEL_OFF : wdata16[1:0];

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			undervoltage_handling_select    <= SEL_OFF;
			undervoltage_torque_limit_level <= LEVEL_RESET;
			torque_limit_release_time       <= RELEASE_RESET;
			power_loss_hold_time            <= HOLD_RESET;
			irq_mask                        <= '0;
		end
		else
		begin
			if (wr_sel)
				undervoltage_handling_select <= sel_new;
			if (wr_level)
				undervoltage_torque_limit_level <= clamp16(wdata16, LEVEL_MIN, LEVEL_MAX);
			if (wr_rel)
				torque_limit_release_time <= clamp16(wdata16, RELEASE_MIN, RELEASE_MAX);
			if (wr_hold)
				power_loss_hold_time <= clamp16(wdata16, HOLD_MIN, HOLD_MAX);
			if (wr_imask)
				irq_mask <= avs_writedata[IRQ_BITS-1:0];
		end
	end

	// Warning follows the bus comparator only when detection is enabled.
	wire detect_on = (undervoltage_handling_select != SEL_OFF);
	wire next_warn = detect_on && bus_low;
	wire drive_mode = (undervoltage_handling_select == SEL_DRIVE);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			warn_d <= 1'b0;
		else
			warn_d <= next_warn;
	end
	assign uv_warning = warn_d;

	// Linear ramp: level + (100 - level) * elapsed / release time.
	wire [15:0] span      = FULL_TORQUE - undervoltage_torque_limit_level;
	wire [31:0] ramp_prod = 32'(span) * 32'(ramp_ms);
	wire [15:0] ramp_add  = 16'(ramp_prod / 32'(torque_limit_release_time));
	wire        ramp_done = (ramp_ms >= torque_limit_release_time);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state   <= ST_NORMAL;
			ramp_ms <= 16'h0;
		end
		else if (!drive_mode)
		begin
			state   <= ST_NORMAL;
			ramp_ms <= 16'h0;
		end
		else
		begin
			case (state)
				ST_NORMAL:
					if (warn_d)
						state <= ST_LIMIT;
				ST_LIMIT:
					if (!warn_d)
					begin
						state   <= ST_RAMP;
						ramp_ms <= 16'h0;
					end
				ST_RAMP:
					if (warn_d)
						state <= ST_LIMIT;
					else if (ramp_done)
						state <= ST_NORMAL;
					else if (tick)
						ramp_ms <= ramp_ms + 16'h1;
				default:
					state <= ST_NORMAL;
			endcase
		end
	end

	// Level changes apply at once because the output is recomputed every cycle.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			torque_limit    <= FULL_TORQUE;
			torque_limit_en <= 1'b0;
		end
		else
		begin
			case (state)
				ST_LIMIT:
				begin
					torque_limit    <= undervoltage_torque_limit_level;
					torque_limit_en <= 1'b1;
				end
				ST_RAMP:
				begin
					torque_limit    <= ramp_done ? FULL_TORQUE
						: undervoltage_torque_limit_level + ramp_add;
					torque_limit_en <= !ramp_done;
				end
				default:
				begin
					torque_limit    <= FULL_TORQUE;
					torque_limit_en <= 1'b0;
				end
			endcase
		end
	end

	// Supply loss timer; a trip holds until the supply returns.
	// Counting one tick past the hold time keeps a partial first millisecond from tripping early.
	wire hold_expired = (loss_ms > power_loss_hold_time);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			loss_ms <= 16'h0;
			tripped <= 1'b0;
		end
		else if (!supply_lost)
		begin
			loss_ms <= 16'h0;
			tripped <= 1'b0;
		end
		else
		begin
			if (tick && !hold_expired)
				loss_ms <= loss_ms + 16'h1;
			if (hold_expired)
				tripped <= 1'b1;
		end
	end

	// The host's servo off acts at once; the hold time never delays it.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			servo_ready     <= 1'b0;
			servo_energized <= 1'b0;
		end
		else
		begin
			servo_ready     <= !tripped;
			servo_energized <= !tripped && servo_on_request && !servo_off_command;
		end
	end

	// Sticky events; a new event beats a simultaneous write-one clear.
	wire [IRQ_BITS-1:0] events = {
		supply_lost && hold_expired && !tripped,
		warn_d && !next_warn,
		next_warn && !warn_d};
	wire [IRQ_BITS-1:0] clr = wr_istat ? avs_writedata[IRQ_BITS-1:0] : '0;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			irq_status <= '0;
		else
			irq_status <= (irq_status & ~clr) | events;
	end
	assign irq = |(irq_status & irq_mask);

	wire [31:0] rd_mux =
		(avs_address == ADDR_SELECT)   ? {30'h0, undervoltage_handling_select} :
		(avs_address == ADDR_LEVEL)    ? {16'h0, undervoltage_torque_limit_level} :
		(avs_address == ADDR_RELEASE)  ? {16'h0, torque_limit_release_time} :
		(avs_address == ADDR_HOLD)     ? {16'h0, power_loss_hold_time} :
		(avs_address == ADDR_STATUS)   ? {27'h0, servo_energized, servo_ready, tripped,
			torque_limit_en, warn_d} :
		(avs_address == ADDR_IRQ_STAT) ? {29'h0, irq_status} :
		(avs_address == ADDR_IRQ_MASK) ? {29'h0, irq_mask} :
		(avs_address == ADDR_LIMIT)    ? {16'h0, torque_limit} : 32'h0;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			avs_readdata <= 32'h0;
		else if (access && avs_read)
			avs_readdata <= rd_mux;
	end

	property warn_off_p;
		@(posedge clk_sys) disable iff (srst)
		(undervoltage_handling_select == SEL_OFF) |=> !uv_warning;
	endproperty
	warn_off_a: assert property (warn_off_p) else $error("warning while detection off");

	warn_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
		(detect_on && bus_low) |=> uv_warning) else $error("warning missed");

	host_noclamp_a: assert property (@(posedge clk_sys) disable iff (srst)
		(undervoltage_handling_select == SEL_HOST) [*3] |-> !torque_limit_en)
		else $error("clamp in host mode");

	clamp_level_a: assert property (@(posedge clk_sys) disable iff (srst)
		(drive_mode && uv_warning) [*3] |-> torque_limit == $past(undervoltage_torque_limit_level))
		else $error("clamp not at level");

	ramp_mono_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state == ST_RAMP && $past(state) == ST_RAMP && $stable(undervoltage_torque_limit_level)
		&& $stable(torque_limit_release_time))
		|-> torque_limit >= $past(torque_limit)) else $error("ramp fell");

	ramp_start_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state == ST_LIMIT && drive_mode && !warn_d) |=> ##1 torque_limit_en)
		else $error("limit dropped at release");

	level_range_a: assert property (@(posedge clk_sys) disable iff (srst)
		undervoltage_torque_limit_level >= LEVEL_MIN && undervoltage_torque_limit_level <= LEVEL_MAX)
		else $error("level out of range");

	release_range_a: assert property (@(posedge clk_sys) disable iff (srst)
		torque_limit_release_time >= RELEASE_MIN && torque_limit_release_time <= RELEASE_MAX)
		else $error("release out of range");

	hold_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
		(supply_lost && !hold_expired && !tripped) |=> servo_ready) else $error("early trip");

	trip_drop_a: assert property (@(posedge clk_sys) disable iff (srst)
		tripped |=> !servo_ready && !servo_energized) else $error("servo kept on");

	off_cmd_a: assert property (@(posedge clk_sys) disable iff (srst)
		servo_off_command |=> !servo_energized) else $error("servo off ignored");

	drive_limit_c: cover property (@(posedge clk_sys) disable iff (srst)
		drive_mode && state == ST_LIMIT ##1 state == ST_RAMP);
	ramp_end_c: cover property (@(posedge clk_sys) disable iff (srst)
		state == ST_RAMP ##1 state == ST_NORMAL);
	trip_c: cover property (@(posedge clk_sys) disable iff (srst) $rose(tripped));
	irq_c: cover property (@(posedge clk_sys) disable iff (srst) $rose(irq));
endmodule
`default_nettype wire

/* File: shared/uv_limit_pkg.sv */
// Purpose: Constants for the undervoltage torque limiter.
// Assumes: 100 MHz clk_sys, Avalon-MM register access with 32-bit data.
// Notes: Register offsets are byte addresses of aligned words.
// How it works
// - Enabled detection plus low bus voltage raises warning and limits motor current.
// - Select value 0, the reset default, detects and reports no undervoltage.
// - Select value 1 reports the warning; the host does the torque limiting.
// - Select value 2 reports the warning and limits torque inside the block.
// - Drive mode: torque clamped to the configured level while warning is active.
// - Drive mode: after release the limit rises gradually over release time.
// - Limit level 10 to 100 percent, default 50, effective immediately.
// - Release time 10 to 1000 ms, default 100, effective immediately.
// - Supply loss shorter than hold time (20 to 50000 ms) keeps servo on.
// - Supply loss longer than hold time drops servo ready and servo on.
package uv_limit_pkg;
	localparam logic [7:0]  ADDR_SELECT   = 8'h00;
	localparam logic [7:0]  ADDR_LEVEL    = 8'h04;
	localparam logic [7:0]  ADDR_RELEASE  = 8'h08;
	localparam logic [7:0]  ADDR_HOLD     = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS   = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0]  ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0]  ADDR_LIMIT    = 8'h1C;
	localparam logic [1:0]  SEL_OFF       = 2'h0;
	localparam logic [1:0]  SEL_HOST      = 2'h1;
	localparam logic [1:0]  SEL_DRIVE     = 2'h2;
	localparam logic [15:0] LEVEL_MIN     = 16'h000A;
	localparam logic [15:0] LEVEL_MAX     = 16'h0064;
	localparam logic [15:0] LEVEL_RESET   = 16'h0032;
	localparam logic [15:0] RELEASE_MIN   = 16'h000A;
	localparam logic [15:0] RELEASE_MAX   = 16'h03E8;
	localparam logic [15:0] RELEASE_RESET = 16'h0064;
	localparam logic [15:0] HOLD_MIN      = 16'h0014;
	localparam logic [15:0] HOLD_MAX      = 16'hC350;
	localparam logic [15:0] HOLD_RESET    = 16'h0014;
	localparam logic [15:0] FULL_TORQUE   = 16'h0064;
	localparam int          CLK_HZ        = 100000000;
	localparam int          TICK_MS       = 1;
	localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int          IRQ_WARN_SET  = 0;
	localparam int          IRQ_WARN_CLR  = 1;
	localparam int          IRQ_TRIP      = 2;
	localparam int          IRQ_BITS      = 3;

	typedef enum logic [1:0] {ST_NORMAL, ST_LIMIT, ST_RAMP} lim_state_t;

	// Clamps a written value into its legal range.
	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
endpackage
